// [rtl/rc_consts.svh]
// Constants shared by both ends of the register-access link.
`ifndef RC_CONSTS_SVH
`define RC_CONSTS_SVH
`define CTL_REG_BIT 7
`define CTL_WR_BIT 6
`define NUM_REGS 64
`define IDENT_REG_NUM 6'h08
`define CODE_REG_NUM 6'h1f
`define FEATURE_REG_NUM 6'h20
`define USER_FIRST_NUM 6'h1f
`define UNLOCK_CODE 16'h1235
`define STORE_RESET 16'h0000
`define OFS_CONTROL 4'h0
`define OFS_WDATA 4'h4
`define OFS_STATUS 4'h8
`define OFS_RDATA 4'hc
`define SETTLE_CYCLES 2'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [rtl/rc_pkg.sv]
// Types and decoding shared by both ends of the register-access link.
`include "rc_consts.svh"
package rc_pkg;
   typedef enum logic [1:0] {
      ACC_PROC = 2'b00,
      ACC_READ = 2'b01,
      ACC_WRITE = 2'b10
   } acc_t;

   function automatic acc_t decode_access(input logic [7:0] c);
      if (!c[`CTL_REG_BIT]) begin
         return ACC_PROC;
      end
      return c[`CTL_WR_BIT] ? ACC_WRITE : ACC_READ;
   endfunction

   function automatic logic [7:0] ack_byte(input logic [7:0] c);
      logic [7:0] a;
      a = c;
      if (decode_access(c) == ACC_WRITE) begin
         a[`CTL_WR_BIT] = 1'b0;
      end
      return a;
   endfunction
endpackage

// [rtl/rc_link_if.sv]
// Process-image link between the controller end and the terminal end.
`timescale 1ns/1ps
`default_nettype none
interface rc_link_if;
   logic [7:0] control_byte;
   logic [15:0] output_data_word;
   logic [7:0] status_byte;
   logic [15:0] input_data_word;

   modport dev (
      input control_byte,
      input output_data_word,
      output status_byte,
      output input_data_word
   );

   modport host (
      output control_byte,
      output output_data_word,
      input status_byte,
      input input_data_word
   );
endinterface
`default_nettype wire

// [rtl/reg_access_device.sv]
// Terminal end: register access over the process image with write protection.
//
// Contract
// - Protected: only register 31 accepts writes.
// - Writing 0x1235 to 31 lifts protection.
// - Other value to 31 restores protection.
// - Written values act only after restart.
// - Control bit 7 high selects register mode.
// - Control bit 6: one write, zero read.
// - Bits 5..0 carry binary register number.
// - Write acknowledged as control with bit 6 cleared.
// - Read acknowledged by echoing control byte.
// - Controller ignores data word after write.
// - Output data word ignored during reads.
// - Read returns addressed register's sixteen bits.
// - Data word: high byte first, low second.
// - Register 31 reads back stored code word.
// - Register 32 holds feature bits.
// - Controller writes 0x0000 to 31 when done.
// - Bit 7 low means process data exchange.
// - Write complete only once acknowledgment shows.
// - Six address bits select 64 registers.
`timescale 1ns/1ps
`default_nettype none
`include "rc_consts.svh"
module reg_access_device #(
   parameter logic [15:0] IDENT_VALUE = 16'h0a5a
) (
   input wire logic aclk,
   input wire logic aresetn,
   rc_link_if.dev link,
   input wire logic store_clear,
   input wire logic [7:0] proc_status,
   input wire logic [15:0] proc_value,
   output logic [15:0] feature_active,
   output logic write_protected
);

   ////////////////////////////////////////////////////////////////////////////
   // Request decoding.

   rc_pkg::acc_t acc;
   logic [5:0] num;
   logic [15:0] wr_word;
   logic num_is_code;
   logic num_is_ident;
   logic wr_ok;
   logic protect_ff;
   logic nxt_protect;

   // A register takes a write when it is the code word or an unlocked user register.
   function automatic logic is_writable(input logic [5:0] n, input logic locked);
      logic user;
      user = (n >= `USER_FIRST_NUM);
      if (n == `CODE_REG_NUM) begin
         return 1'b1;
      end
      return user && !locked;
   endfunction

   assign acc = rc_pkg::decode_access(link.control_byte);
   assign num = link.control_byte[5:0];
   assign wr_word = link.output_data_word;
   assign num_is_code = (num == `CODE_REG_NUM);
   assign num_is_ident = (num == `IDENT_REG_NUM);
   assign wr_ok = (acc == rc_pkg::ACC_WRITE) && is_writable(num, protect_ff);

   ////////////////////////////////////////////////////////////////////////////
   // Write protection flag.

   // Every cycle that a write to the code-word register stands applies the lock decision again.
   always_comb begin
      nxt_protect = protect_ff;
      if ((acc == rc_pkg::ACC_WRITE) && num_is_code) begin
         if (wr_word == `UNLOCK_CODE) begin
            nxt_protect = 1'b0;
         end else begin
            nxt_protect = 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         protect_ff <= 1'b1;
      end else begin
         protect_ff <= nxt_protect;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // One write enable for each register of the store.

   logic [`NUM_REGS-1:0] wr_sel;

   generate
      for (genvar j = 0; j < `NUM_REGS; j++) begin : g_sel
         assign wr_sel[j] = wr_ok && (num == 6'(j));
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Retained register store; it keeps its contents across a reset.

   logic [15:0] store_ff [0:`NUM_REGS-1];

   generate
      for (genvar i = 0; i < `NUM_REGS; i++) begin : g_store
         always_ff @(posedge aclk) begin
            if (store_clear) begin
               store_ff[i] <= `STORE_RESET;
            end else if (wr_sel[i]) begin
               store_ff[i] <= wr_word;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Read selection.

   logic [15:0] rd_value;

   // The identity register is fixed; every other number reads the store.
   always_comb begin
      if (num_is_ident) begin
         rd_value = IDENT_VALUE;
      end else begin
         rd_value = store_ff[num];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Settings in force; the feature value is loaded only at restart.

   logic [15:0] feature_active_ff;
   logic [15:0] nxt_feature;

   // Holding reset stands in for a power cycle of the terminal.
   always_comb begin
      nxt_feature = feature_active_ff;
      if (!aresetn) begin
         nxt_feature = store_ff[`FEATURE_REG_NUM];
      end
   end

   always_ff @(posedge aclk) begin
      feature_active_ff <= nxt_feature;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input image: status byte and input data word.

   logic [7:0] status_ff;
   logic [15:0] in_word_ff;
   logic [7:0] nxt_status;
   logic [15:0] nxt_in_word;

   // Each answer belongs to the request sampled one cycle earlier.
   always_comb begin
      case (acc)
         rc_pkg::ACC_WRITE: begin
            nxt_status = rc_pkg::ack_byte(link.control_byte);
            nxt_in_word = 16'h0000;
         end
         rc_pkg::ACC_READ: begin
            nxt_status = link.control_byte;
            nxt_in_word = rd_value;
         end
         default: begin
            nxt_status = proc_status;
            nxt_in_word = proc_value;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered input image.

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_ff <= 8'h00;
      end else begin
         status_ff <= nxt_status;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in_word_ff <= 16'h0000;
      end else begin
         in_word_ff <= nxt_in_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign link.status_byte = status_ff;
   assign link.input_data_word = in_word_ff;
   assign feature_active = feature_active_ff;
   assign write_protected = protect_ff;

endmodule
`default_nettype wire

// [rtl/reg_access_host.sv]
// Controller end: AXI4-Lite register slave driving the process-image link.
`timescale 1ns/1ps
`default_nettype none
`include "rc_consts.svh"
module reg_access_host (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   rc_link_if.host link
);

   ////////////////////////////////////////////////////////////////////////////
   // Write channel capture.

   logic awready_ff;
   logic wready_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic aw_have_ff;
   logic w_have_ff;
   logic [3:0] aw_addr_ff;
   logic [31:0] w_data_ff;
   logic [3:0] w_strb_ff;
   logic do_write;

   assign do_write = aw_have_ff && w_have_ff && !bvalid_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b1;
         aw_have_ff <= 1'b0;
         aw_addr_ff <= 4'h0;
      end else if (s_axi_awvalid && awready_ff) begin
         awready_ff <= 1'b0;
         aw_have_ff <= 1'b1;
         aw_addr_ff <= s_axi_awaddr;
      end else if (do_write) begin
         aw_have_ff <= 1'b0;
      end else if (bvalid_ff && s_axi_bready) begin
         awready_ff <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_ff <= 1'b1;
         w_have_ff <= 1'b0;
         w_data_ff <= 32'h0000_0000;
         w_strb_ff <= 4'h0;
      end else if (s_axi_wvalid && wready_ff) begin
         wready_ff <= 1'b0;
         w_have_ff <= 1'b1;
         w_data_ff <= s_axi_wdata;
         w_strb_ff <= s_axi_wstrb;
      end else if (do_write) begin
         w_have_ff <= 1'b0;
      end else if (bvalid_ff && s_axi_bready) begin
         wready_ff <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= `RESP_OKAY;
      end else if (do_write) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= (aw_addr_ff == `OFS_CONTROL || aw_addr_ff == `OFS_WDATA) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output image registers.

   logic [7:0] control_ff;
   logic [15:0] wdata_ff;
   logic [1:0] settle_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         control_ff <= 8'h00;
         settle_ff <= 2'h0;
      end else if (do_write && aw_addr_ff == `OFS_CONTROL && w_strb_ff[0]) begin
         control_ff <= w_data_ff[7:0];
         settle_ff <= `SETTLE_CYCLES;
      end else if (settle_ff != 2'h0) begin
         settle_ff <= settle_ff - 2'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdata_ff <= 16'h0000;
      end else if (do_write && aw_addr_ff == `OFS_WDATA) begin
         for (int b = 0; b < 2; b++) begin
            if (w_strb_ff[b]) begin
               wdata_ff[8*b +: 8] <= w_data_ff[8*b +: 8];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Acknowledgment tracking; stale status is masked while the new request settles.

   rc_pkg::acc_t acc;
   logic match;
   logic done_ff;
   logic [15:0] rdata_ff;

   assign acc = rc_pkg::decode_access(control_ff);
   assign match = (acc != rc_pkg::ACC_PROC) && (link.status_byte == rc_pkg::ack_byte(control_ff));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         done_ff <= 1'b0;
      end else begin
         done_ff <= (settle_ff == 2'h0) && match && !(do_write && aw_addr_ff == `OFS_CONTROL);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rdata_ff <= 16'h0000;
      end else if ((settle_ff == 2'h0) && match && (acc == rc_pkg::ACC_READ)) begin
         rdata_ff <= link.input_data_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channel.

   logic arready_ff;
   logic rvalid_ff;
   logic [31:0] rdata_out_ff;
   logic [1:0] rresp_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         rdata_out_ff <= 32'h0000_0000;
         rresp_ff <= `RESP_OKAY;
      end else if (s_axi_arvalid && arready_ff) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b1;
         rresp_ff <= `RESP_OKAY;
         case (s_axi_araddr)
            `OFS_CONTROL: rdata_out_ff <= {24'h00_0000, control_ff};
            `OFS_WDATA: rdata_out_ff <= {16'h0000, wdata_ff};
            `OFS_STATUS: rdata_out_ff <= {23'h00_0000, done_ff, link.status_byte};
            `OFS_RDATA: rdata_out_ff <= {16'h0000, rdata_ff};
            default: begin
               rdata_out_ff <= 32'h0000_0000;
               rresp_ff <= `RESP_SLVERR;
            end
         endcase
      end else if (rvalid_ff && s_axi_rready) begin
         rvalid_ff <= 1'b0;
         arready_ff <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_out_ff;
   assign s_axi_rresp = rresp_ff;
   assign link.control_byte = control_ff;
   assign link.output_data_word = wdata_ff;

endmodule
`default_nettype wire

// [tb/rc_link_assertions.sv]
// Checker of the link that joins the two ends.
`timescale 1ns/1ps
`default_nettype none
module rc_link_assertions #(
   parameter logic [15:0] IDENT_VALUE = 16'h0a5a
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] control_byte,
   input wire logic [15:0] output_data_word,
   input wire logic [7:0] status_byte,
   input wire logic [15:0] input_data_word
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic open_ff;
   // Tracks whether the code word has lifted protection.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         open_ff <= 1'b0;
      end else if (control_byte == 8'hdf) begin
         open_ff <= output_data_word == 16'h1235;
      end
   end
   logic code_seen_ff;
   logic user_seen_ff;
   logic [15:0] code_ff;
   logic [5:0] user_num_ff;
   logic [15:0] user_word_ff;
   // Remembers the last code word and the last user write that protection let through.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         code_seen_ff <= 1'b0;
         user_seen_ff <= 1'b0;
      end else begin
         if (control_byte == 8'hdf) begin
            code_seen_ff <= 1'b1;
         end
         if (open_ff && control_byte[7:5] == 3'b111) begin
            user_seen_ff <= 1'b1;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (control_byte == 8'hdf) begin
         code_ff <= output_data_word;
      end
      if (open_ff && control_byte[7:5] == 3'b111) begin
         user_num_ff <= control_byte[5:0];
         user_word_ff <= output_data_word;
      end
   end
   a_write_ack: assert property (control_byte[7:6] == 2'b11 |=> status_byte == ($past(control_byte) & 8'hbf))
      else $error("write acknowledge wrong");
   a_read_echo: assert property (control_byte[7:6] == 2'b10 |=> status_byte == $past(control_byte))
      else $error("read acknowledge wrong");
   a_write_zero: assert property (control_byte[7:6] == 2'b11 |=> input_data_word == 16'h0000)
      else $error("word after write not zero");
   a_read_steady: assert property (control_byte[7:6] == 2'b10 ##1 $stable(control_byte) |=> $stable(input_data_word))
      else $error("read word moved");
   a_ident_read: assert property (control_byte == 8'h88 |=> input_data_word == IDENT_VALUE)
      else $error("register 8 wrong");
   a_code_readback: assert property (code_seen_ff && control_byte == 8'h9f |=> input_data_word == code_ff)
      else $error("code word readback wrong");
   a_user_write: assert property (user_seen_ff && control_byte == {2'b10, user_num_ff} |=> input_data_word == user_word_ff)
      else $error("unlocked write not stored");
   a_ack_steady: assert property (control_byte[7] && $stable(control_byte) |=> $stable(status_byte))
      else $error("status moved");
endmodule
`default_nettype wire

// [tb/test_register_access_write_protect.sv]
// Bench joining both ends of the register-access link.
`timescale 1ns/1ps
`default_nettype none
module test_register_access_write_protect;
   logic aclk, aresetn = 1'b0, store_clear = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, write_protected;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic [1:0] bresp, rresp;
   logic [7:0] proc_status = 8'h41;
   logic [15:0] proc_value = 16'h7e81, feature_active;
   int miscompares = 0, checked = 0, cycles = 0;
   rc_link_if rc_link_if_i ();
   reg_access_device reg_access_device_i (.aclk(aclk), .aresetn(aresetn), .link(rc_link_if_i), .store_clear(store_clear),
      .proc_status(proc_status), .proc_value(proc_value), .feature_active(feature_active), .write_protected(write_protected));
   reg_access_host reg_access_host_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .link(rc_link_if_i));
   rc_link_assertions #(.IDENT_VALUE(16'h0a5a)) rc_link_assertions_i (.aclk(aclk), .aresetn(aresetn),
      .control_byte(rc_link_if_i.control_byte), .output_data_word(rc_link_if_i.output_data_word),
      .status_byte(rc_link_if_i.status_byte), .input_data_word(rc_link_if_i.input_data_word));
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares = miscompares + 1;
         end_sim();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      if (miscompares == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (aw && awready === 1'b1) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready === 1'b1) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) begin
            arvalid <= 1'b0;
         end
      end while (rvalid !== 1'b1);
      d = rdata;
      rready <= 1'b0;
   endtask
   task automatic wait_done();
      logic [31:0] s;
      s = 32'h0000_0000;
      while (s[8] !== 1'b1) begin
         rd(4'h8, s);
      end
   endtask
   task automatic reg_write(input logic [5:0] n, input logic [15:0] val);
      logic [1:0] r;
      wr(4'h0, 32'h0000_0000, r);
      wr(4'h4, {16'h0000, val}, r);
      wr(4'h0, {24'h00_0000, 2'b11, n}, r);
      wait_done();
      chk(rc_link_if_i.status_byte, {2'b10, n});
   endtask
   task automatic reg_read(input logic [5:0] n, input logic [15:0] exp);
      logic [1:0] r;
      logic [31:0] d;
      wr(4'h0, {24'h00_0000, 2'b10, n}, r);
      wait_done();
      rd(4'hc, d);
      chk(d, {16'h0000, exp});
      chk(rc_link_if_i.status_byte, {2'b10, n});
      wr(4'h4, 32'h0000_a5a5, r);
      chk(rc_link_if_i.input_data_word, exp);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_map();
      logic [31:0] d;
      logic [1:0] r;
      chk(write_protected, 1'b1);
      rd(4'h0, d);
      chk(d, 32'h0000_0000);
      wr(4'h8, 32'h0000_00ff, r);
      chk(r, 2'h2);
   endtask
   task automatic t_unlock();
      reg_write(6'h20, 16'h0002);
      reg_read(6'h20, 16'h0000);
      reg_write(6'h1f, 16'h1235);
      chk(write_protected, 1'b0);
      chk(rc_link_if_i.output_data_word[15:8], 8'h12);
      reg_read(6'h1f, 16'h1235);
      reg_write(6'h20, 16'h0002);
      reg_read(6'h20, 16'h0002);
      chk(feature_active, 16'h0000);
      reg_write(6'h3f, 16'hbeef);
      reg_read(6'h3f, 16'hbeef);
      reg_write(6'h08, 16'h1111);
      reg_read(6'h08, 16'h0a5a);
      reg_write(6'h1f, 16'h1234);
      chk(write_protected, 1'b1);
      reg_write(6'h1f, 16'h1235);
      reg_write(6'h1f, 16'h0000);
      chk(write_protected, 1'b1);
      reg_write(6'h20, 16'h5555);
      reg_read(6'h20, 16'h0002);
   endtask
   task automatic t_restart();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk(feature_active, 16'h0002);
      chk(write_protected, 1'b1);
   endtask
   task automatic t_proc();
      logic [1:0] r;
      wr(4'h0, 32'h0000_0005, r);
      repeat (2) @(posedge aclk);
      chk(rc_link_if_i.status_byte, 8'h41);
      chk(rc_link_if_i.input_data_word, 16'h7e81);
   endtask
   initial begin
      repeat (3) @(posedge aclk);
      store_clear <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_map();
      t_unlock();
      t_restart();
      t_proc();
      end_sim();
   end
endmodule
`default_nettype wire
